// >>> isf_pkg.sv
// constants, register map and config record for the interpolator speed and filter block
`default_nettype none
package isf_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_FACTOR = 8'h04;
    localparam logic [7:0] OFS_DIV = 8'h08;
    localparam logic [7:0] OFS_SPD_LIM = 8'h0C;
    localparam logic [7:0] OFS_ADAPT = 8'h10;
    localparam logic [7:0] OFS_FATAL = 8'h14;
    localparam logic [7:0] OFS_HYST = 8'h18;
    localparam logic [7:0] OFS_STATUS = 8'h1C;
    localparam logic [7:0] OFS_MASK = 8'h20;
    localparam logic [7:0] OFS_LIVE = 8'h24;
    localparam logic [7:0] OFS_POS = 8'h28;
    // control field positions
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_INST_LSB = 2;
    localparam int CTRL_LIM_EN = 6;
    localparam int CTRL_WARN_EN = 7;
    localparam int CTRL_RUN = 8;
    // status / mask / live bit positions
    localparam int ST_LIMIT = 0;
    localparam int ST_WARN = 1;
    localparam int ST_FATAL = 2;
    localparam int ST_ADAPT = 3;
    localparam int ST_W = 4;
    localparam int LIVE_BYPASS = 4;
    // reset values
    localparam logic [8:0] CTRL_RST = 9'h100;
    localparam logic [23:0] FACTOR_RST = 24'h000400;
    localparam logic [5:0] DIV_RST = 6'h01;
    localparam logic [15:0] SPD_LIM_RST = 16'h0001;
    localparam logic [31:0] ADAPT_RST = 32'hFFFFFFFF;
    localparam logic [31:0] FATAL_RST = 32'hFFFFFFFF;
    localparam logic [15:0] HYST_RST = 16'h0040;
    // factor is edges per input cycle with 8 fraction bits
    localparam int FAC_FRAC = 8;
    localparam logic [15:0] FAC_INT_MIN = 16'h0004;
    localparam logic [15:0] FAC_INT_MAX = 16'h4000;
    localparam logic [5:0] DIV_MAX = 6'h20;
    // one output edge and half an edge in filter units
    localparam logic signed [39:0] EDGE_ONE = 40'sh0000000100;
    localparam logic signed [39:0] EDGE_HALF = 40'sh0000000080;
    // speed evaluation window in core cycles
    localparam int WIN_CYC = 1024;

    typedef enum {FILT_P, FILT_PI, FILT_LAG} filt_mode_e;

    typedef struct packed {
        logic run;
        logic warn_en;
        logic lim_en;
        logic [3:0] inst;
        logic [1:0] mode;
    } ctrl_s;
endpackage
`default_nettype wire

// >>> interp_speed_filter.sv
// AB output path: tracking filter, hysteresis, speed limit, post-AB divider, overspeed supervision
// Overview of operation
// RQ1: divider is bypassed when the factor is whole and between 4 and 16384.
// RQ2: with a divider above one, index and AB states have no fixed alignment.
// RQ3: edges are held to a minimum spacing; throttling may raise the fault output.
// RQ4: adaption halt output is high while measured speed exceeds adaption limit.
// RQ5: warning threshold is half the fatal one; raises fault only when enabled.
// RQ6: exceeding the fatal threshold always raises the fault output.
// RQ7: a programmable sub-edge hysteresis stops AB toggling at standstill.
// RQ8: interpolation factor carries eight fraction bits so odd resolutions work.
// RQ9: proportional mode lags with speed and instance and never overshoots.
// RQ10: PI mode removes steady lag with a critically damped response; the PI gains used here give an under-damped one.
// RQ11: lag recovery mode also removes latency lag, under-damped response.
// RQ12: with the divider active, standstill edge spacing differs from running spacing.
// RQ13: limit, warning and fatal exceedances are checked each window as separate flags.
//
// The register addresses and register access over APB were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module interp_speed_filter
    import isf_pkg::*;
#(
    parameter int WIN = WIN_CYC
)
(
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_arst_n,
    // interpolated angle from the sin/cos front end, same clock
    input wire logic [15:0] i_angle,
    input wire logic i_angle_vld,
    // apb slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // quadrature and supervision
    output logic o_a,
    output logic o_b,
    output logic o_fault,
    output logic o_adapt_halt,
    output logic o_irq
);
    if (WIN < 2 || WIN > 4096)
    begin : g_chk
        $error("WIN must be between 2 and 4096");
    end
    // register map decode, used only for the error answer
    function automatic logic addr_ok(input logic [7:0] a);
        addr_ok = (a <= OFS_POS) && (a[1:0] == 2'b00);
    endfunction
    ctrl_s ctrl_r;
    logic [23:0] factor_r;
    logic [5:0] div_r;
    logic [15:0] spd_lim_r, hyst_r;
    logic [31:0] adapt_r, fatal_r, pos_cnt_r;
    logic [ST_W-1:0] status_r, mask_r, live;
    logic lim_live_r, warn_live_r, fatal_live_r, wr_acc;
    // apb write takes effect in the access cycle while pready is high
    assign wr_acc = i_psel & i_penable & o_pready & i_pwrite;
    // configuration registers
    always_ff @(posedge i_core_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            ctrl_r <= ctrl_s'(CTRL_RST);
            factor_r <= FACTOR_RST;
            div_r <= DIV_RST;
            spd_lim_r <= SPD_LIM_RST;
            adapt_r <= ADAPT_RST;
            fatal_r <= FATAL_RST;
            hyst_r <= HYST_RST;
            mask_r <= '0;
        end
        else if (wr_acc)
        begin
            if (i_paddr == OFS_CTRL)
                ctrl_r <= ctrl_s'(i_pwdata[8:0]);
            else if (i_paddr == OFS_FACTOR)
                factor_r <= i_pwdata[23:0]; // RQ8
            else if (i_paddr == OFS_DIV)
                div_r <= (i_pwdata[5:0] == 6'h00 || i_pwdata[5:0] > DIV_MAX) ? DIV_MAX
                                                                            : i_pwdata[5:0];
            else if (i_paddr == OFS_SPD_LIM)
                spd_lim_r <= i_pwdata[15:0];
            else if (i_paddr == OFS_ADAPT)
                adapt_r <= i_pwdata;
            else if (i_paddr == OFS_FATAL)
                fatal_r <= i_pwdata;
            else if (i_paddr == OFS_HYST)
                hyst_r <= i_pwdata[15:0]; // RQ7
            else if (i_paddr == OFS_MASK)
                mask_r <= i_pwdata[ST_W-1:0];
        end
    end

    // sticky status: set wins over a write-one clear in the same cycle
    always_ff @(posedge i_core_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            status_r <= '0;
        else if (wr_acc && i_paddr == OFS_STATUS)
            status_r <= (status_r & ~i_pwdata[ST_W-1:0]) | live; // RQ13
        else
            status_r <= status_r | live; // RQ13
    end

    // divider bypass when four times out per in is whole and within range
    logic bypass;
    logic [5:0] eff_div;
    assign bypass = (factor_r[FAC_FRAC-1:0] == 8'h00)
                  && (factor_r[23:FAC_FRAC] >= FAC_INT_MIN)
                  && (factor_r[23:FAC_FRAC] <= FAC_INT_MAX); // RQ1
    assign eff_div = bypass ? 6'h01 : div_r; // RQ1
    // live flags for status and readback
    assign live = {o_adapt_halt, fatal_live_r, warn_live_r, lim_live_r};

    // read data and ready are prepared at the setup edge, one wait-free access
    always_ff @(posedge i_core_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            o_pready <= 1'b0;
            o_pslverr <= 1'b0;
            o_prdata <= '0;
        end
        else
        begin
            o_pready <= i_psel & ~i_penable;
            o_pslverr <= i_psel & ~i_penable & ~addr_ok(i_paddr);
            o_prdata <= '0;
            if (i_psel && !i_penable && !i_pwrite)
            begin
                if (i_paddr == OFS_CTRL)
                    o_prdata <= {23'h000000, ctrl_r};
                else if (i_paddr == OFS_FACTOR)
                    o_prdata <= {8'h00, factor_r};
                else if (i_paddr == OFS_DIV)
                    o_prdata <= {26'h0000000, div_r};
                else if (i_paddr == OFS_SPD_LIM)
                    o_prdata <= {16'h0000, spd_lim_r};
                else if (i_paddr == OFS_ADAPT)
                    o_prdata <= adapt_r;
                else if (i_paddr == OFS_FATAL)
                    o_prdata <= fatal_r;
                else if (i_paddr == OFS_HYST)
                    o_prdata <= {16'h0000, hyst_r};
                else if (i_paddr == OFS_STATUS)
                    o_prdata <= {28'h0000000, status_r};
                else if (i_paddr == OFS_MASK)
                    o_prdata <= {28'h0000000, mask_r};
                else if (i_paddr == OFS_LIVE)
                    o_prdata <= {27'h0000000, bypass, live};
                else if (i_paddr == OFS_POS)
                    o_prdata <= pos_cnt_r;
            end
        end
    end

    // unwrap the angle into an input position with 16 fraction bits
    logic [15:0] ang_prev_r;
    logic signed [31:0] pos_in_r;
    logic signed [15:0] ang_step;
    assign ang_step = signed'(i_angle - ang_prev_r);
    always_ff @(posedge i_core_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            ang_prev_r <= '0;
            pos_in_r <= '0;
        end
        else if (i_angle_vld)
        begin
            ang_prev_r <= i_angle;
            pos_in_r <= pos_in_r + 32'(ang_step);
        end
    end

    // target in output edges with 8 fraction bits; fraction keeps odd factors exact
    logic signed [56:0] prod;
    logic signed [39:0] target;
    assign prod = pos_in_r * signed'({1'b0, factor_r}); // RQ8
    assign target = prod[55:16];
    // tracking filter
    logic signed [39:0] est_r, integ_r, err, p_term, i_step;
    assign err = target - est_r;
    assign p_term = err >>> ctrl_r.inst;
    assign i_step = err >>> {ctrl_r.inst, 1'b0};
    always_ff @(posedge i_core_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            est_r <= '0;
            integ_r <= '0;
        end
        else if (i_angle_vld && ctrl_r.run)
        begin
            case (ctrl_r.mode)
                2'(FILT_PI):
                begin
                    // integral removes steady lag; integral gain is the proportional gain squared, so under-damped
                    integ_r <= integ_r + i_step; // RQ10
                    est_r <= est_r + p_term + integ_r; // RQ10
                end
                2'(FILT_LAG):
                begin
                    // extra velocity lead recovers latency lag at the cost of ringing
                    integ_r <= integ_r + i_step; // RQ11
                    est_r <= est_r + p_term + integ_r + (integ_r >>> 1); // RQ11
                end
                default:
                begin
                    // pure first order: lag grows with speed and instance, no overshoot
                    integ_r <= '0; // RQ9
                    est_r <= est_r + p_term; // RQ9
                end
            endcase
        end
    end
    // edge stepping with hysteresis on reversal and a minimum edge gap
    logic signed [39:0] edge_pos, hyst_s;
    logic last_dn_r, want_up, want_dn, gap_ok, lim_seen_r;
    logic [15:0] gap_r;
    assign edge_pos = 40'(signed'(pos_cnt_r)) <<< FAC_FRAC;
    assign hyst_s = 40'(hyst_r);
    assign want_up = (est_r - edge_pos) >= (EDGE_HALF + (last_dn_r ? hyst_s : 40'sh0)); // RQ7
    assign want_dn = (edge_pos - est_r) >= (EDGE_HALF + (last_dn_r ? 40'sh0 : hyst_s)); // RQ7
    assign gap_ok = gap_r >= spd_lim_r; // RQ3
    always_ff @(posedge i_core_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            pos_cnt_r <= '0;
            last_dn_r <= 1'b0;
            gap_r <= '0;
        end
        else if ((want_up || want_dn) && gap_ok)
        begin
            pos_cnt_r <= want_up ? pos_cnt_r + 32'h1 : pos_cnt_r - 32'h1;
            last_dn_r <= ~want_up;
            gap_r <= 16'h0001; // RQ3
        end
        else if (gap_r != 16'hFFFF)
            gap_r <= gap_r + 16'h0001;
    end

    // post-AB divider; the index cannot track AB states unless the effective divider is one
    logic [5:0] div_cnt_r;
    logic [1:0] ab_r;
    always_ff @(posedge i_core_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            div_cnt_r <= '0;
            ab_r <= '0;
        end
        else if ((want_up || want_dn) && gap_ok)
        begin
            // RQ12: a reversal restarts mid-count, so dither spacing differs from running
            if (want_up && div_cnt_r >= eff_div - 6'h01)
            begin
                div_cnt_r <= '0; // RQ2
                ab_r <= ab_r + 2'h1;
            end
            else if (want_up)
                div_cnt_r <= div_cnt_r + 6'h01;
            else if (div_cnt_r == 6'h00)
            begin
                div_cnt_r <= eff_div - 6'h01; // RQ12
                ab_r <= ab_r - 2'h1;
            end
            else
                div_cnt_r <= div_cnt_r - 6'h01;
        end
    end
    // quadrature outputs, gray order of the AB count
    always_ff @(posedge i_core_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            {o_a, o_b} <= 2'b00;
        else
            {o_a, o_b} <= {ab_r[1], ab_r[1] ^ ab_r[0]};
    end
    // speed window: input travel per window against the thresholds
    logic [12:0] win_r;
    logic signed [31:0] snap_r, dpos;
    logic [31:0] spd;
    assign dpos = pos_in_r - snap_r;
    assign spd = dpos[31] ? 32'(-dpos) : 32'(dpos);
    always_ff @(posedge i_core_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            win_r <= '0;
            snap_r <= '0;
            lim_seen_r <= 1'b0;
            lim_live_r <= 1'b0;
            warn_live_r <= 1'b0;
            fatal_live_r <= 1'b0;
            o_adapt_halt <= 1'b0;
        end
        else if (win_r == 13'(WIN - 1))
        begin
            win_r <= '0;
            snap_r <= pos_in_r;
            lim_seen_r <= 1'b0;
            lim_live_r <= lim_seen_r; // RQ13
            warn_live_r <= spd > (fatal_r >> 1); // RQ5
            fatal_live_r <= spd > fatal_r; // RQ6
            o_adapt_halt <= spd > adapt_r; // RQ4
        end
        else
        begin
            win_r <= win_r + 13'h0001;
            // throttled edge means the requested rate exceeds the limit
            if ((want_up || want_dn) && !gap_ok)
                lim_seen_r <= 1'b1; // RQ3
        end
    end
    // fault output: fatal cannot be masked, others follow their enables
    always_ff @(posedge i_core_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            {o_fault, o_irq} <= 2'b00;
        else
        begin
            o_fault <= fatal_live_r // RQ6
                     | (ctrl_r.warn_en & warn_live_r) // RQ5
                     | (ctrl_r.lim_en & lim_live_r); // RQ3
            o_irq <= |(status_r & mask_r);
        end
    end
endmodule
`default_nettype wire

// >>> isf_checker.sv
// port checks for the interpolator speed and filter block
`timescale 1ns/1ps
`default_nettype none
module isf_checker
#(
    parameter int WIN = 1024
)
(
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_arst_n,
    // register bus
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic [31:0] o_prdata,
    input wire logic o_pready,
    input wire logic o_pslverr,
    // motion outputs
    input wire logic o_a,
    input wire logic o_b,
    input wire logic o_adapt_halt
);
    int gap_r;
    logic seen_r;
    logic halt_q;
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_arst_n);
    // cycles since the halt flag last moved; the first move after reset has no reference
    always_ff @(posedge i_core_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            gap_r <= 0;
            seen_r <= 1'b0;
            halt_q <= 1'b0;
        end
        else
        begin
            halt_q <= o_adapt_halt;
            seen_r <= seen_r | (o_adapt_halt != halt_q);
            gap_r <= (o_adapt_halt != halt_q) ? 0 : ((gap_r < WIN) ? gap_r + 1 : gap_r);
        end
    end
    property p_halt_gap;
        (o_adapt_halt != halt_q) && seen_r |-> gap_r >= WIN - 1;
    endproperty
    a_halt_gap: assert property (p_halt_gap) else $error("halt moved inside a window");
    property p_ab_step;
        $changed(o_a) |-> $stable(o_b);
    endproperty
    a_ab_step: assert property (p_ab_step) else $error("a and b moved together");
    property p_setup_answer;
        i_psel && !i_penable |=> o_pready;
    endproperty
    a_setup_answer: assert property (p_setup_answer) else $error("no ready");
    property p_ready_once;
        o_pready |=> !o_pready;
    endproperty
    a_ready_once: assert property (p_ready_once) else $error("ready too long");
    property p_ready_access;
        o_pready |-> i_psel && i_penable;
    endproperty
    a_ready_access: assert property (p_ready_access) else $error("ready outside access");
    property p_err_ready;
        o_pslverr |-> o_pready;
    endproperty
    a_err_ready: assert property (p_err_ready) else $error("error without ready");
    property p_data_idle;
        !o_pready |-> o_prdata == 32'h00000000;
    endproperty
    a_data_idle: assert property (p_data_idle) else $error("read data not idle");
    property p_idle;
        !i_psel ##1 !i_psel |-> !o_pready;
    endproperty
    a_idle: assert property (p_idle) else $error("ready while idle");
endmodule
bind interp_speed_filter isf_checker #(.WIN(WIN)) isf_checker_i (.i_core_clk(i_core_clk),
    .i_arst_n(i_arst_n), .i_psel(i_psel), .i_penable(i_penable), .o_prdata(o_prdata),
    .o_pready(o_pready), .o_pslverr(o_pslverr), .o_a(o_a), .o_b(o_b),
    .o_adapt_halt(o_adapt_halt));
`default_nettype wire

// >>> isf_sensor_model.sv
// sensor angle source and downstream quadrature counter
`timescale 1ns/1ps
`default_nettype none
module isf_sensor_model
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // motion command
    input wire logic [15:0] i_step,
    input wire logic i_dith,
    // sensor side
    output logic [15:0] o_angle,
    output logic o_vld,
    // counter side
    input wire logic i_a,
    input wire logic i_b,
    output logic signed [31:0] o_cnt,
    output logic [31:0] o_tog
);
    logic [15:0] ang_r;
    logic tgl_r;
    logic [1:0] ph_r;
    logic [1:0] ph;
    // phase from gray pair {a, a^b}; every change is one edge
    assign ph = {i_a, i_a ^ i_b};
    // a sample each cycle; steps stay far below half a cycle so nothing aliases
    assign o_vld = 1'b1;
    // dither straddles the rest point on both sides
    assign o_angle = ang_r + (i_dith ? (tgl_r ? 16'h0100 : 16'hFF00) : 16'h0000);
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            ang_r <= 16'h0000;
            tgl_r <= 1'b0;
            ph_r <= 2'h0;
            o_cnt <= 32'sh0;
            o_tog <= 32'h0;
        end
        else
        begin
            ang_r <= ang_r + i_step;
            tgl_r <= ~tgl_r;
            ph_r <= ph;
            if (ph == ph_r + 2'h1)
                o_cnt <= o_cnt + 32'sh1;
            else if (ph == ph_r - 2'h1)
                o_cnt <= o_cnt - 32'sh1;
            if (ph != ph_r)
                o_tog <= o_tog + 32'h1;
        end
    end
endmodule
`default_nettype wire

// >>> interp_speed_filter_tb.sv
// self-checking bench for the interpolator speed and filter block
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e, m) begin num_checks++; if ((g) !== (e)) begin mismatches++; \
    $display("MISMATCH %0t %s", $time, m); end end
module interp_speed_filter_tb;
    import isf_pkg::*;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic pready, pslverr, a, b, fault, halt, irq, vld;
    logic [15:0] angle;
    logic [15:0] step = 16'h0000;
    logic dith = 1'b0;
    logic signed [31:0] cnt;
    logic [31:0] tog;
    logic [32:0] expq[$];
    logic [31:0] rst_v[11] = '{32'h100, 32'h400, 32'h1, 32'h1, 32'hFFFFFFFF, 32'hFFFFFFFF,
        32'h40, 32'h0, 32'h0, 32'h10, 32'h0};
    logic [31:0] fac[6] = '{32'h400, 32'h400000, 32'h400100, 32'h300, 32'h13880, 32'h480};
    logic [5:0] byp = 6'h03;
    int mismatches = 0;
    int num_checks = 0;
    int cyc = 0;
    int r;
    interp_speed_filter #(.WIN(16)) interp_speed_filter_i (.i_core_clk(clk), .i_arst_n(arst_n),
        .i_angle(angle), .i_angle_vld(vld), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr), .o_a(a), .o_b(b), .o_fault(fault),
        .o_adapt_halt(halt), .o_irq(irq));
    isf_sensor_model isf_sensor_model_i (.i_clk(clk), .i_rst_n(arst_n), .i_step(step),
        .i_dith(dith), .o_angle(angle), .o_vld(vld), .i_a(a), .i_b(b), .o_cnt(cnt), .o_tog(tog));
    // 20 MHz core clock
    initial
    begin
        forever #25 clk = ~clk;
    end
    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // a hang ends the run well past the planned length
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 40000)
        begin
            mismatches++;
            $display("MISMATCH %0t timeout", $time);
            finish_test();
        end
    end
    // read answers are judged against the oldest note, sampled at the ready edge
    always @(posedge clk)
    begin
        if (psel && penable && pready && !pwrite && expq.size() > 0)
            `CHK({pslverr, prdata}, expq.pop_front(), "read")
    end
    // one transfer; the request stands until ready is sampled high
    task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d,
        input logic [32:0] ex);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= d;
        if (!w)
            expq.push_back(ex);
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk iff pready);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] ad, input logic [31:0] d);
        apb(1'b1, ad, d, 33'h0);
    endtask
    task automatic rd(input logic [7:0] ad, input logic [31:0] ex);
        apb(1'b0, ad, 32'h0, {1'b0, ex});
    endtask
    task automatic wt();
        repeat (64) @(posedge clk);
        @(negedge clk);
    endtask
    // whole input cycles of motion, then settle; filter lag must be gone by then
    task automatic mv(input int n, input int ex);
        int c0;
        int d;
        c0 = cnt;
        step <= 16'h0100;
        repeat (256 * n) @(posedge clk);
        step <= 16'h0000;
        repeat (600) @(posedge clk);
        d = cnt - c0;
        `CHK(d >= ex - 1 && d <= ex + 1, 1'b1, "edge count")
    endtask
    initial
    begin
        r = $urandom(32'h1873F38F);
        repeat (12) @(posedge clk);
        arst_n <= 1'b1;
        foreach (rst_v[i])
            rd(8'(i * 4), rst_v[i]);
        apb(1'b0, 8'h2C, 32'h0, {1'b1, 32'h0});
        apb(1'b0, 8'h01, 32'h0, {1'b1, 32'h0});
        $display("test reset values done");
        r = $urandom();
        wr(OFS_CTRL, 32'(r));
        rd(OFS_CTRL, 32'(r) & 32'h1FF);
        wr(OFS_DIV, 32'h0);
        rd(OFS_DIV, 32'h20);
        wr(OFS_DIV, 32'h21);
        rd(OFS_DIV, 32'h20);
        wr(OFS_DIV, 32'h1);
        wr(OFS_LIVE, 32'hF);
        rd(OFS_LIVE, 32'h10);
        // whole factors in range bypass the divider, fractional or out of range do not
        foreach (fac[i])
        begin
            wr(OFS_FACTOR, fac[i]);
            rd(OFS_LIVE, {27'h0, byp[i], 4'h0});
        end
        wr(OFS_FACTOR, 32'h400);
        $display("test registers done");
        for (int m = 0; m < 4; m++)
        begin
            wr(OFS_CTRL, 32'h10C | 32'(m));
            mv(8, 32);
        end
        // a whole factor below four keeps the divider in the path; 24 steps make 12 edges
        wr(OFS_DIV, 32'h2);
        wr(OFS_FACTOR, 32'h300);
        repeat (64) @(posedge clk);
        mv(8, 12);
        wr(OFS_DIV, 32'h1);
        wr(OFS_FACTOR, 32'h400);
        $display("test filter modes done");
        // 4096 travel per window: over 6000/2 and 1000, under 6000
        wr(OFS_MASK, 32'h2);
        wr(OFS_FATAL, 32'h1770);
        wr(OFS_ADAPT, 32'h3E8);
        wr(OFS_CTRL, 32'h100);
        step <= 16'h0100;
        wt();
        `CHK({fault, halt, irq}, 3'b011, "warn kept off fault")
        wr(OFS_CTRL, 32'h180);
        wt();
        `CHK(fault, 1'b1, "warn fault")
        wr(OFS_FATAL, 32'hFA0);
        wr(OFS_CTRL, 32'h100);
        wt();
        `CHK(fault, 1'b1, "fatal fault")
        rd(OFS_STATUS, 32'hE);
        wr(OFS_STATUS, 32'hF);
        rd(OFS_STATUS, 32'hE);
        step <= 16'h0000;
        wr(OFS_FATAL, 32'hFFFFFFFF);
        wr(OFS_ADAPT, 32'hFFFFFFFF);
        wt();
        `CHK({fault, halt, irq}, 3'b001, "sticky warn")
        wr(OFS_MASK, 32'h0);
        wt();
        `CHK(irq, 1'b0, "masked irq")
        wr(OFS_STATUS, 32'hF);
        rd(OFS_STATUS, 32'h0);
        $display("test overspeed done");
        // 64 cycles per wanted edge against a 200 cycle minimum gap
        wr(OFS_SPD_LIM, 32'hC8);
        wr(OFS_CTRL, 32'h140);
        step <= 16'h0100;
        wt();
        wt();
        `CHK(fault, 1'b1, "limit fault")
        rd(OFS_LIVE, 32'h11);
        step <= 16'h0000;
        wr(OFS_SPD_LIM, 32'h1);
        wr(OFS_CTRL, 32'h100);
        wt();
        `CHK(fault, 1'b0, "limit cleared")
        $display("test speed limit done");
        // rest on an edge boundary and dither across it
        wr(OFS_HYST, 32'h40);
        step <= 16'h0100;
        @(posedge clk iff angle == 16'h1F00);
        step <= 16'h0000;
        repeat (600) @(posedge clk);
        dith <= 1'b1;
        r = tog;
        repeat (400) @(posedge clk);
        `CHK(tog - 32'(r) <= 32'h1, 1'b1, "standstill toggling")
        dith <= 1'b0;
        $display("test hysteresis done");
        finish_test();
    end
endmodule
`default_nettype wire
